// [interrupt_vector_ack_logic.sv]
// interrupt enable gating, priority, vector generation and acknowledge cycles
// Function
// (RULE_01) dma enable bits 2,1,0 gate three requests; the code gates all eight dma requests with bits 7..0
// (RULE_02) timer enable bits 7..4 gate timers, reset 0
// (RULE_03) timer enable low nibble reserved, reads zero
// (RULE_04) vector driven only on low data byte
// (RULE_05) fixed mode outputs stored 8-bit vector unchanged
// (RULE_06) modified mode: software bits 7:6, code 5:0
// (RULE_07) vector select picks fixed or modified vector
// (RULE_08) non-acknowledge mode never drives the bus
// (RULE_09) single mode drives vector on first ack
// (RULE_10) double mode skips first ack, drives second
// (RULE_11) ack field: 01 single, 10 double, else none
// (RULE_12) no vector when request output inactive
// (RULE_13) serial codes: channel, type bits, zero lsb
// (RULE_14) dma source codes per channel and request
// (RULE_15) timer codes, lowest priorities 17 to 20
// (RULE_16) priority order depends on vector select
// (RULE_17) request asserted while pending and enabled
// (RULE_18) modified code from highest active source
// (RULE_19) status bits follow sources, clear on reset
module interrupt_vector_ack_logic
    import irq_vec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // source requests: rx_ready, tx_ready, rx_status, tx_status per channel
    input wire logic [1:0] rx_ready_req,
    input wire logic [1:0] tx_ready_req,
    input wire logic [1:0] rx_status_req,
    input wire logic [1:0] tx_status_req,
    input wire logic [3:0] dma_req_a,
    input wire logic [3:0] dma_req_b,
    input wire logic [3:0] timer_req,
    // host side
    output logic irq_n,
    input wire logic irq_ack_n,
    output logic [15:0] data_out,
    output logic [15:0] data_oe
);
    // ****************************************
    // registers and state
    // ****************************************
    logic [7:0] serialEn_reg;
    logic [7:0] dmaEn_reg;
    logic [7:0] timerEn_reg;
    logic [7:0] fixedVec_reg;
    logic [7:0] modVecHi_reg;
    logic [7:0] control_reg;
    logic [7:0] serialSt_reg;
    logic [7:0] dmaSt_reg;
    logic [7:0] timerSt_reg;
    logic ackPrev_reg;
    ack_state_t ackState_reg;
    ack_state_t ackState_next;
    logic [7:0] awAddr_reg;
    logic awHeld_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic wHeld_reg;
    logic [19:0] active;
    logic anyActive;
    logic [5:0] code;
    logic [7:0] vector;
    logic [1:0] ackMode;
    logic ackFall;
    logic ackRise;
    logic doWrite;
    logic [7:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [7:0] wByte;

    // find first set bit, lowest index wins
    function automatic logic [4:0] first_set(input logic [19:0] v);
        logic [4:0] idx;
        idx = 5'd0;
        for (int i = 19; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // ****************************************
    // status and request
    // ****************************************
    // status mirrors the sources, cleared on reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serialSt_reg <= REG_RESET; // RULE_19
            dmaSt_reg <= REG_RESET;
            timerSt_reg <= REG_RESET;
        end else begin
            serialSt_reg <= {tx_status_req[1], rx_status_req[1],
                tx_ready_req[1], rx_ready_req[1], tx_status_req[0],
                rx_status_req[0], tx_ready_req[0], rx_ready_req[0]}; // RULE_19
            dmaSt_reg <= {dma_req_b[3], dma_req_a[3], dma_req_b[2],
                dma_req_a[2], dma_req_b[1], dma_req_a[1], dma_req_b[0],
                dma_req_a[0]};
            timerSt_reg <= {timer_req, 4'h0};
        end
    end

    // pending and enabled, in priority table order; each enable bit
    // gates the status bit at the same position
    always_comb begin
        active[7:0] = serialSt_reg & serialEn_reg;
        active[15:8] = dmaSt_reg & dmaEn_reg; // RULE_01
        active[19:16] = timerSt_reg[7:4] & timerEn_reg[7:4]; // RULE_02
    end
    assign anyActive = |active;

    // active-low request from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~anyActive; // RULE_17
        end
    end

    // ****************************************
    // priority and vector
    // ****************************************
    // vector select 1 rotates dma ahead of serial; timers always last
    always_comb begin
        logic [19:0] ordered;
        logic [4:0] idx;
        ordered = active;
        idx = 5'd0;
        if (control_reg[CTL_VSEL_BIT]) begin
            ordered = {active[19:16], active[7:0], active[15:8]}; // RULE_16
        end
        idx = first_set(ordered); // RULE_18
        // with nothing active the code stays that of source 1
        if (control_reg[CTL_VSEL_BIT] && anyActive && idx < 5'd16) begin
            idx = (idx < 5'd8) ? idx + 5'd8 : idx - 5'd8;
        end
        code = SRC_CODE[idx]; // RULE_13 RULE_14 RULE_15
        if (control_reg[CTL_VSEL_BIT]) begin
            vector = {modVecHi_reg[7:6], code}; // RULE_06 RULE_07
        end else begin
            vector = fixedVec_reg; // RULE_05 RULE_07
        end
    end

    // ****************************************
    // acknowledge cycle
    // ****************************************
    assign ackMode = {control_reg[CTL_ACK_HI_BIT],
        control_reg[CTL_ACK_LO_BIT]};
    assign ackFall = ackPrev_reg & ~irq_ack_n;
    assign ackRise = ~ackPrev_reg & irq_ack_n;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ackPrev_reg <= 1'b1;
        end else begin
            ackPrev_reg <= irq_ack_n;
        end
    end

    // next acknowledge state
    always_comb begin
        ackState_next = ackState_reg;
        case (ackState_reg)
            ACK_IDLE: begin
                if (ackFall && !irq_n) begin // RULE_12
                    if (ackMode == ACK_SINGLE) begin
                        ackState_next = ACK_DRIVE; // RULE_09 RULE_11
                    end else if (ackMode == ACK_DOUBLE) begin
                        ackState_next = ACK_SKIP; // RULE_10 RULE_11
                    end
                end
            end
            ACK_SKIP: begin
                if (ackMode != ACK_DOUBLE) begin
                    ackState_next = ACK_IDLE;
                end else if (ackFall) begin
                    ackState_next = irq_n ? ACK_IDLE : ACK_DRIVE; // RULE_12
                end
            end
            ACK_DRIVE: begin
                if (ackRise) begin
                    ackState_next = ACK_IDLE;
                end
            end
            default: ackState_next = ACK_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ackState_reg <= ACK_IDLE;
        end else begin
            ackState_reg <= ackState_next;
        end
    end

    // bus drive: low byte only, upper byte held zero and undriven
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out <= 16'h0000;
            data_oe <= 16'h0000;
        end else if (ackState_next == ACK_DRIVE) begin
            data_oe <= 16'h00ff; // RULE_04 RULE_08
            if (ackState_reg != ACK_DRIVE) begin
                data_out <= {8'h00, vector}; // RULE_04
            end
        end else begin
            data_oe <= 16'h0000; // RULE_08 RULE_10
        end
    end

    // ****************************************
    // axi4-lite write
    // ****************************************
    assign wAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    assign wData = wHeld_reg ? wData_reg : s_axi_wdata;
    assign wStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    assign wByte = wData[7:0];
    assign doWrite = (awHeld_reg || (s_axi_awvalid && s_axi_awready))
        && (wHeld_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

    // capture address and data in either order, answer once both held
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_reg <= s_axi_awaddr;
                awHeld_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
                wHeld_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wAddr == OFF_SERIAL_EN
                    || wAddr == OFF_DMA_EN || wAddr == OFF_TIMER_EN
                    || wAddr == OFF_FIXED_VEC || wAddr == OFF_MOD_VEC
                    || wAddr == OFF_CONTROL || wAddr == OFF_SERIAL_ST
                    || wAddr == OFF_DMA_ST || wAddr == OFF_TIMER_ST)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register writes, low byte lane only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serialEn_reg <= REG_RESET;
            dmaEn_reg <= REG_RESET;
            timerEn_reg <= REG_RESET; // RULE_02
            fixedVec_reg <= REG_RESET;
            modVecHi_reg <= REG_RESET;
            control_reg <= REG_RESET;
        end else if (doWrite && wStrb[0]) begin
            if (wAddr == OFF_SERIAL_EN) begin
                serialEn_reg <= wByte;
            end else if (wAddr == OFF_DMA_EN) begin
                dmaEn_reg <= wByte; // RULE_01
            end else if (wAddr == OFF_TIMER_EN) begin
                timerEn_reg <= wByte & TIMER_EN_MASK; // RULE_03
            end else if (wAddr == OFF_FIXED_VEC) begin
                fixedVec_reg <= wByte; // RULE_05
            end else if (wAddr == OFF_MOD_VEC) begin
                modVecHi_reg <= wByte & MODVEC_SW_MASK; // RULE_06
            end else if (wAddr == OFF_CONTROL) begin
                control_reg <= wByte & CTL_WRITE_MASK;
            end
        end
    end

    // ****************************************
    // axi4-lite read
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == OFF_SERIAL_EN) begin
                s_axi_rdata <= {24'h0, serialEn_reg};
            end else if (s_axi_araddr == OFF_DMA_EN) begin
                s_axi_rdata <= {24'h0, dmaEn_reg};
            end else if (s_axi_araddr == OFF_TIMER_EN) begin
                s_axi_rdata <= {24'h0, timerEn_reg}; // RULE_03
            end else if (s_axi_araddr == OFF_FIXED_VEC) begin
                s_axi_rdata <= {24'h0, fixedVec_reg};
            end else if (s_axi_araddr == OFF_MOD_VEC) begin
                s_axi_rdata <= {24'h0, modVecHi_reg[7:6], code};
            end else if (s_axi_araddr == OFF_CONTROL) begin
                s_axi_rdata <= {24'h0, control_reg};
            end else if (s_axi_araddr == OFF_SERIAL_ST) begin
                s_axi_rdata <= {24'h0, serialSt_reg}; // RULE_19
            end else if (s_axi_araddr == OFF_DMA_ST) begin
                s_axi_rdata <= {24'h0, dmaSt_reg};
            end else if (s_axi_araddr == OFF_TIMER_ST) begin
                s_axi_rdata <= {24'h0, timerSt_reg};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// [irq_vec_pkg.sv]
// package of register offsets, fields, reset values and codes for the irq block
package irq_vec_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_SERIAL_EN = 8'h00;
    localparam logic [7:0] OFF_DMA_EN = 8'h04;
    localparam logic [7:0] OFF_TIMER_EN = 8'h08;
    localparam logic [7:0] OFF_FIXED_VEC = 8'h0c;
    localparam logic [7:0] OFF_MOD_VEC = 8'h10;
    localparam logic [7:0] OFF_CONTROL = 8'h14;
    localparam logic [7:0] OFF_SERIAL_ST = 8'h18;
    localparam logic [7:0] OFF_DMA_ST = 8'h1c;
    localparam logic [7:0] OFF_TIMER_ST = 8'h20;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTL_ACK_LO_BIT = 5;
    localparam int CTL_ACK_HI_BIT = 6;
    localparam int CTL_VSEL_BIT = 4;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h70;
    localparam logic [7:0] TIMER_EN_MASK = 8'hf0;
    localparam logic [7:0] MODVEC_SW_MASK = 8'hc0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // acknowledge mode encodings (hi, lo)
    localparam logic [1:0] ACK_NONE = 2'b00;
    localparam logic [1:0] ACK_SINGLE = 2'b01;
    localparam logic [1:0] ACK_DOUBLE = 2'b10;
    // source codes in bits 5..0, index 0..19 in table order
    localparam logic [5:0] SRC_CODE [20] = '{
        6'h04, 6'h06, 6'h08, 6'h0a, 6'h24, 6'h26, 6'h28, 6'h2a,
        6'h14, 6'h16, 6'h18, 6'h1a, 6'h34, 6'h36, 6'h38, 6'h3a,
        6'h1c, 6'h1e, 6'h3c, 6'h3e};
    typedef enum logic [2:0] {
        ACK_IDLE = 3'b001,
        ACK_SKIP = 3'b010,
        ACK_DRIVE = 3'b100
    } ack_state_t;
endpackage

// [interrupt_vector_ack_logic_checker.sv]
// port-level assertions for the interrupt vector and acknowledge block
module interrupt_vector_ack_logic_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] rx_ready_req,
    input wire logic [1:0] tx_ready_req,
    input wire logic [1:0] rx_status_req,
    input wire logic [1:0] tx_status_req,
    input wire logic [3:0] dma_req_a,
    input wire logic [3:0] dma_req_b,
    input wire logic [3:0] timer_req,
    input wire logic irq_n,
    input wire logic irq_ack_n,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // vector bus: low byte only, driving starts on a sampled ack fall
    upper_byte_a: assert property (
        (data_oe == 16'h0 || data_oe == 16'h00ff) && data_out[15:8] == 8'h0)
        else $error("bus enable or upper byte out of range");
    ack_start_a: assert property (
        $rose(data_oe[0]) |-> !$past(irq_ack_n) && $past(irq_ack_n, 2)
        && !$past(irq_n))
        else $error("vector driven without a qualified ack");
    vec_hold_a: assert property (
        data_oe[0] && !irq_ack_n |=> data_oe[0] && $stable(data_out[7:0]))
        else $error("vector dropped while ack low");
    vec_release_a: assert property (
        data_oe[0] && irq_ack_n |=> data_oe == 16'h0)
        else $error("bus still driven after ack released");
    // no request at the inputs leaves the request output inactive
    no_request_a: assert property (
        ~|{rx_ready_req, tx_ready_req, rx_status_req, tx_status_req,
        dma_req_a, dma_req_b, timer_req} |-> ##2 irq_n)
        else $error("request active without sources");
    // register bus answers and recovery
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write response missing");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not recovered");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    rd_done_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not recovered");
endmodule

bind interrupt_vector_ack_logic interrupt_vector_ack_logic_checker chk_u (
    .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .rx_ready_req,
    .tx_ready_req, .rx_status_req, .tx_status_req, .dma_req_a, .dma_req_b,
    .timer_req, .irq_n, .irq_ack_n, .data_out, .data_oe);

// [host_ack_model.sv]
// host processor model that runs interrupt acknowledge pulses
module host_ack_model (
    input wire logic ref_clk,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    output logic irq_ack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial irq_ack_n = 1'b1;
    // one low pulse of three cycles, two high cycles after it
    task automatic ack_pulse(output logic drove, output logic [7:0] vec);
        drove = 1'b0;
        vec = 8'h00;
        @(posedge ref_clk);
        irq_ack_n <= 1'b0;
        repeat (3) begin
            @(posedge ref_clk);
            if (data_oe === 16'h00ff) begin
                drove = 1'b1;
                vec = data_out[7:0];
            end
        end
        irq_ack_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule

// [interrupt_vector_ack_logic_tb.sv]
// self-checking bench for the interrupt vector and acknowledge block
module interrupt_vector_ack_logic_tb import irq_vec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_n, irq_ack_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr, fixv, modv, got;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, dma_req_a, dma_req_b, timer_req;
    logic [1:0] s_axi_bresp, s_axi_rresp, rx_ready_req, tx_ready_req;
    logic [1:0] rx_status_req, tx_status_req, mode, resp;
    logic [15:0] data_out, data_oe;
    logic [19:0] src, en;
    logic [6:0] top;
    logic vsel, drove, expDrove;
    logic [7:0] expVec;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] rstAddr [5] = '{OFF_SERIAL_EN, OFF_DMA_EN, OFF_TIMER_EN,
        OFF_FIXED_VEC, OFF_CONTROL};

    interrupt_vector_ack_logic dut_u (.ref_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_ready_req, .tx_ready_req, .rx_status_req, .tx_status_req,
        .dma_req_a, .dma_req_b, .timer_req, .irq_n, .irq_ack_n, .data_out,
        .data_oe);
    host_ack_model host_u (.ref_clk, .data_out, .data_oe, .irq_ack_n);

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [7:0] g, input logic [7:0] e,
        input string what);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                g, e);
        end
    endtask
    // address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata[7:0];
        resp = s_axi_rresp;
    endtask
    // source code of table index i, serial, dma and timer groups
    function automatic logic [5:0] src_code(int i);
        if (i < 16) return {i[2], i[3], 3'(2 + i[1:0]), 1'b0};
        return {i[1], 3'b111, i[0], 1'b0};
    endfunction
    // highest priority active source, found flag on top
    function automatic logic [6:0] top_src(logic [19:0] act, logic vs);
        int idx;
        for (int n = 0; n < 20; n++) begin
            idx = (vs && n < 16) ? (n + 8) % 16 : n;
            if (act[idx]) return {1'b1, src_code(idx)};
        end
        return {1'b0, 6'h04};
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h7a52));
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'b1000;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, rx_ready_req, tx_ready_req} = '0;
        {rx_status_req, tx_status_req, dma_req_a, dma_req_b, timer_req} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            axi_read(rstAddr[i], got);
            check(got, 8'h00, "reset value");
        end
        axi_read(OFF_MOD_VEC, got);
        check(got, 8'h04, "modified vector reset");
        axi_read(8'h40, got);
        check({6'h0, resp}, {6'h0, RESP_SLVERR}, "unmapped read");
        axi_write(8'h40, 8'h00);
        check({6'h0, resp}, {6'h0, RESP_SLVERR}, "unmapped write");
        // a write without the low byte lane leaves the register alone
        s_axi_wstrb <= 4'he;
        axi_write(OFF_FIXED_VEC, 8'h5a);
        s_axi_wstrb <= 4'hf;
        axi_read(OFF_FIXED_VEC, got);
        check(got, REG_RESET, "write without low lane");
        axi_write(OFF_TIMER_EN, 8'hff);
        check({6'h0, resp}, {6'h0, RESP_OKAY}, "write response");
        axi_read(OFF_TIMER_EN, got);
        check(got, 8'hf0, "timer enable reserved bits");
        for (int k = 0; k < 16; k++) begin
            src = 20'($urandom & $urandom & $urandom);
            en = (k % 7 == 5) ? 20'h0 : 20'($urandom);
            mode = k[1:0];
            vsel = k[2];
            fixv = 8'($urandom);
            modv = 8'($urandom);
            @(posedge ref_clk);
            rx_ready_req <= {src[4], src[0]};
            tx_ready_req <= {src[5], src[1]};
            rx_status_req <= {src[6], src[2]};
            tx_status_req <= {src[7], src[3]};
            dma_req_a <= {src[14], src[12], src[10], src[8]};
            dma_req_b <= {src[15], src[13], src[11], src[9]};
            timer_req <= src[19:16];
            axi_write(OFF_SERIAL_EN, en[7:0]);
            axi_write(OFF_DMA_EN, en[15:8]);
            axi_write(OFF_TIMER_EN, {en[19:16], 4'h0});
            axi_write(OFF_FIXED_VEC, fixv);
            axi_write(OFF_MOD_VEC, modv);
            axi_write(OFF_CONTROL, {1'b0, mode, vsel, 4'h0});
            repeat (3) @(posedge ref_clk);
            top = top_src(src & en, vsel);
            check({7'h0, irq_n}, {7'h0, !top[6]}, "irq out");
            axi_read(OFF_SERIAL_ST, got);
            check(got, src[7:0], "serial status");
            axi_read(OFF_DMA_ST, got);
            check(got, src[15:8], "dma status");
            axi_read(OFF_TIMER_ST, got);
            check(got, {src[19:16], 4'h0}, "timer status");
            axi_read(OFF_MOD_VEC, got);
            check(got, {modv[7:6], top[5:0]}, "modified vector");
            host_u.ack_pulse(drove, got);
            expDrove = mode == ACK_SINGLE && top[6];
            check({7'h0, drove}, {7'h0, expDrove}, "first ack");
            if (mode == ACK_DOUBLE) begin
                host_u.ack_pulse(drove, got);
                check({7'h0, drove}, {7'h0, top[6]}, "second ack");
            end
            expVec = vsel ? {modv[7:6], top[5:0]} : fixv;
            if (drove === 1'b1) begin
                check(got, expVec, "vector");
            end
        end
        tally_and_finish();
    end
endmodule
